// [rtl/sdt_timer.sv]
// Purpose: 16-bit standard timer with compare, timer and PWM behaviour
// Assumes: one clock; byte registers on a plain strobe port
// Notes: flags and the PWM pin follow the count with one cycle of latency, the compare pin with two
//
// Summary of operation
// - compare-A value in two byte registers
// - period byte compared with count upper byte
// - period zero gives 65536 clocks, else times 256
// - mode field picks compare, timer or PWM
// - clear-select low clears on P, sets both flags
// - clear-select high clears on A, A flag only
// - compare-A zero overflows at ffff, no A flag
// - compare mode pin changes only on A flag or run start
// - pin action sets, clears or toggles pin
// - run rising edge restores pin initial level
// - timer mode counts alike, pin not driven
// - PWM ignores clear-select, swap picks roles
// - swap low: period byte sets period
// - duty at or above period gives 100%
// - swap high: compare-A sets period
// - PWM sets both flags on their matches
// - output control and polarity shape PWM level
// - pin action forces pin, counting keeps running
// - running count readable as two bytes
// - output control sets initial or active level
// - polarity inverts output, not in timer mode
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "sdt_params.svh"
module sdt_timer
    import sdt_pkg::*;
(
    input wire logic i_ref_clk, // timer clock, 100 MHz
    input wire logic i_rst_b, // asynchronous reset, active low
    input wire logic [2:0] i_addr, // register address
    input wire logic [7:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [7:0] o_rdata, // read data, cycle after i_rd
    output logic o_timer_output_pin, // timer output pin level
    output logic o_timer_output_pin_oe, // pin driven by the timer
    output logic o_compare_a_flag, // sticky compare-A flag
    output logic o_compare_p_flag, // sticky compare-P flag
    output logic o_run // run bit
);
    logic rst_b;
    logic run_r;
    logic [7:0] ctrl1_r;
    logic [15:0] cmpa_r;
    logic [7:0] period_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic flag_a_r;
    logic flag_a_nxt;
    logic flag_p_r;
    logic flag_p_nxt;
    logic pin_level_r;
    logic pin_level_nxt;
    logic out_r;
    logic out_nxt;
    logic oe_r;
    logic oe_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rd_mux;
    logic a_match;
    logic a_zero;
    logic p_match;
    logic pwm_active;

    // mode field to behaviour; capture and pulse codes act as timer
    function automatic sdt_beh_t beh_of(input logic [1:0] code);
        sdt_beh_t beh;
        beh = SDT_BEH_TIMER;
        if (code == `SDT_MODE_CMP) begin
            beh = SDT_BEH_COMPARE;
        end else if (code == `SDT_MODE_PWM) begin
            beh = SDT_BEH_PWM;
        end
        return beh;
    endfunction : beh_of

    sdt_rst_sync u_rst_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .o_rst_b(rst_b)
    );

    sdt_compare u_compare (
        .i_count(cnt_r),
        .i_compare_a(cmpa_r),
        .i_period_value(period_r),
        .i_swap(ctrl1_r[`SDT_SWAP_BIT]),
        .o_a_match(a_match),
        .o_a_zero(a_zero),
        .o_p_match(p_match),
        .o_pwm_active(pwm_active)
    );

    // address decode of the strobe port
    wire wr_ctrl0 = i_wr && (i_addr == `SDT_ADDR_CTRL0);
    wire wr_ctrl1 = i_wr && (i_addr == `SDT_ADDR_CTRL1);
    wire wr_cmpa_lo = i_wr && (i_addr == `SDT_ADDR_CMPA_LO);
    wire wr_cmpa_hi = i_wr && (i_addr == `SDT_ADDR_CMPA_HI);
    wire wr_period = i_wr && (i_addr == `SDT_ADDR_PERIOD);
    wire wr_flags = i_wr && (i_addr == `SDT_ADDR_FLAGS);

    // control fields
    wire [1:0] mode_code = ctrl1_r[`SDT_MODE_HI:`SDT_MODE_LO];
    wire [1:0] pin_act = ctrl1_r[`SDT_ACT_HI:`SDT_ACT_LO];
    wire oc_bit = ctrl1_r[`SDT_OC_BIT];
    wire pol_bit = ctrl1_r[`SDT_POL_BIT];
    wire swap_bit = ctrl1_r[`SDT_SWAP_BIT];
    wire clr_sel = ctrl1_r[`SDT_CLRSEL_BIT];
    wire sdt_beh_t beh = beh_of(mode_code);
    wire is_pwm = (beh == SDT_BEH_PWM);
    wire is_cmp = (beh == SDT_BEH_COMPARE);

    // start pulse: only a write turning the run bit from 0 to 1
    wire run_start = wr_ctrl0 && i_wdata[`SDT_RUN_BIT] && !run_r;

    // matches count only while running; compare-A zero never flags
    wire a_hit = run_r && a_match && !a_zero;
    wire p_hit = run_r && p_match;

    // clear source: PWM by swap, otherwise by clear-select
    wire clr_src = is_pwm ? swap_bit : clr_sel;
    wire cnt_clear = clr_src ? a_hit : p_hit;
    wire a_set = a_hit;
    wire p_set = p_hit && (is_pwm || !clr_sel);

    // counter; overflow at ffff wraps to zero by itself
    always_comb begin
        cnt_nxt = cnt_r;
        if (run_start) begin
            cnt_nxt = `SDT_RST_WORD;
        end else if (run_r && cnt_clear) begin
            cnt_nxt = `SDT_RST_WORD;
        end else if (run_r) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    // sticky flags; a set in the clearing cycle wins
    assign flag_a_nxt = a_set ||
        (flag_a_r && !(wr_flags && i_wdata[`SDT_FLAG_A_BIT]));
    assign flag_p_nxt = p_set ||
        (flag_p_r && !(wr_flags && i_wdata[`SDT_FLAG_P_BIT]));

    // compare pin level; only an A event or a run start moves it
    always_comb begin
        pin_level_nxt = pin_level_r;
        if (run_start) begin
            pin_level_nxt = oc_bit;
        end else if (a_set && is_cmp) begin
            unique case (pin_act)
                `SDT_ACT_NONE: pin_level_nxt = pin_level_r;
                `SDT_ACT_LOW: pin_level_nxt = 1'b0;
                `SDT_ACT_HIGH: pin_level_nxt = 1'b1;
                `SDT_ACT_TOGGLE: pin_level_nxt = !pin_level_r;
            endcase
        end
    end

    // pwm level: active level is oc_bit, action may force the pin
    wire pwm_wave = pwm_active ? oc_bit : !oc_bit;
    wire pwm_level = (pin_act == `SDT_ACT_NONE) ? 1'b0 :
                     (pin_act == `SDT_ACT_LOW) ? 1'b1 :
                     pwm_wave;

    // driven level; polarity applies wherever the pin is driven
    always_comb begin
        out_nxt = 1'b0;
        oe_nxt = 1'b0;
        unique case (beh)
            SDT_BEH_COMPARE: begin
                out_nxt = pin_level_r ^ pol_bit;
                oe_nxt = 1'b1;
            end
            SDT_BEH_PWM: begin
                out_nxt = pwm_level ^ pol_bit;
                oe_nxt = 1'b1;
            end
            SDT_BEH_TIMER: begin
                out_nxt = 1'b0;
                oe_nxt = 1'b0;
            end
        endcase
    end

    // read mux; unmapped bits read as zero
    always_comb begin
        rd_mux = `SDT_RST_BYTE;
        unique case (i_addr)
            `SDT_ADDR_CTRL0: rd_mux = {7'h00, run_r};
            `SDT_ADDR_CTRL1: rd_mux = ctrl1_r;
            `SDT_ADDR_CNT_LO: rd_mux = cnt_r[7:0];
            `SDT_ADDR_CNT_HI: rd_mux = cnt_r[15:8];
            `SDT_ADDR_CMPA_LO: rd_mux = cmpa_r[7:0];
            `SDT_ADDR_CMPA_HI: rd_mux = cmpa_r[15:8];
            `SDT_ADDR_PERIOD: rd_mux = period_r;
            `SDT_ADDR_FLAGS: rd_mux = {6'h00, flag_p_r, flag_a_r};
        endcase
    end

    // software registers
    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_r <= 1'b0;
            ctrl1_r <= `SDT_RST_BYTE;
            cmpa_r <= `SDT_RST_WORD;
            period_r <= `SDT_RST_BYTE;
        end else begin
            if (wr_ctrl0) run_r <= i_wdata[`SDT_RUN_BIT];
            if (wr_ctrl1) ctrl1_r <= i_wdata;
            if (wr_cmpa_lo) cmpa_r[7:0] <= i_wdata;
            if (wr_cmpa_hi) cmpa_r[15:8] <= i_wdata;
            if (wr_period) period_r <= i_wdata;
        end
    end

    // timer state; flags follow the count one cycle later, the compare pin two cycles later
    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= `SDT_RST_WORD;
            flag_a_r <= 1'b0;
            flag_p_r <= 1'b0;
            pin_level_r <= 1'b0;
            out_r <= 1'b0;
            oe_r <= 1'b0;
            rdata_r <= `SDT_RST_BYTE;
        end else begin
            cnt_r <= cnt_nxt;
            flag_a_r <= flag_a_nxt;
            flag_p_r <= flag_p_nxt;
            pin_level_r <= pin_level_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            rdata_r <= i_rd ? rd_mux : `SDT_RST_BYTE;
        end
    end

    assign o_rdata = rdata_r;
    assign o_timer_output_pin = out_r;
    assign o_timer_output_pin_oe = oe_r;
    assign o_compare_a_flag = flag_a_r;
    assign o_compare_p_flag = flag_p_r;
    assign o_run = run_r;

    // checks of the timer behaviour
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_b);

    property p_cmpa_read;
        i_rd && (i_addr == `SDT_ADDR_CMPA_HI) |=>
            o_rdata == $past(cmpa_r[15:8]);
    endproperty
    a_cmpa_read: assert property (p_cmpa_read)
        else $error("compare-A high byte reads back wrong");

    property p_period_clear;
        run_r && !run_start && !is_pwm && !clr_sel &&
        (period_r != 8'h00) && (cnt_r[15:8] == period_r - 8'h01) &&
        (cnt_r[7:0] == 8'hff) |=> (cnt_r == 16'h0000) && o_compare_p_flag;
    endproperty
    a_period_clear: assert property (p_period_clear)
        else $error("period match did not clear count and flag");

    property p_no_pflag;
        is_cmp && clr_sel && !$past(p_set) |=> !$rose(o_compare_p_flag);
    endproperty
    a_no_pflag: assert property (p_no_pflag)
        else $error("compare-P flag raised with clear-select high");

    property p_zero_cmpa;
        run_r && (cmpa_r == 16'h0000) && !wr_flags &&
        !flag_a_r |=> !o_compare_a_flag;
    endproperty
    a_zero_cmpa: assert property (p_zero_cmpa)
        else $error("compare-A flag raised with zero compare value");

    property p_pin_still;
        is_cmp && !a_set && !run_start && !wr_ctrl1 |=>
            $stable(pin_level_r);
    endproperty
    a_pin_still: assert property (p_pin_still)
        else $error("compare pin moved without an A event");

    property p_toggle;
        is_cmp && a_set && !run_start && !wr_ctrl1 &&
        (pin_act == `SDT_ACT_TOGGLE) |=> ##1
            o_timer_output_pin == !$past(o_timer_output_pin, 1);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle action did not invert the pin");

    property p_run_start;
        run_start && !wr_ctrl1 |=> (cnt_r == 16'h0000) &&
            (pin_level_r == oc_bit) && run_r;
    endproperty
    a_run_start: assert property (p_run_start)
        else $error("run start did not restart count and pin");

    property p_timer_idle;
        (beh == SDT_BEH_TIMER) && !wr_ctrl1 |=> !o_timer_output_pin_oe;
    endproperty
    a_timer_idle: assert property (p_timer_idle)
        else $error("pin driven in timer mode");

    property p_full_duty;
        is_pwm && !swap_bit && !wr_ctrl1 && pin_act[1] &&
        (period_r != 8'h00) && (cmpa_r >= {period_r, 8'h00}) |=>
            o_timer_output_pin == (oc_bit ^ pol_bit);
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("duty above period is not fully active");

    property p_pwm_count;
        is_pwm && run_r && !run_start && !wr_ctrl0 &&
        (pin_act == `SDT_ACT_NONE) && !cnt_clear |=>
            cnt_r == $past(cnt_r) + 16'h0001;
    endproperty
    a_pwm_count: assert property (p_pwm_count)
        else $error("pwm count stalled while pin forced");

    // period match in pwm must always leave its flag behind
    property p_pwm_pflag;
        is_pwm && p_hit |=> o_compare_p_flag;
    endproperty
    a_pwm_pflag: assert property (p_pwm_pflag)
        else $error("compare-P flag missing on pwm period match");

    // live count, no snapshot between the two byte reads
    property p_count_read;
        i_rd && (i_addr == `SDT_ADDR_CNT_LO) |=>
            o_rdata == $past(cnt_r[7:0]);
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("count low byte reads back wrong");

    c_cmp_toggle: cover property (is_cmp && a_set &&
        (pin_act == `SDT_ACT_TOGGLE));
    c_pwm_period: cover property (is_pwm && p_set && !swap_bit);
    c_pwm_swap: cover property (is_pwm && a_set && swap_bit);
    c_flag_race: cover property (a_set && wr_flags &&
        i_wdata[`SDT_FLAG_A_BIT]);

endmodule : sdt_timer

// [shared/sdt_params.svh]
// Purpose: offsets, field positions, reset values and codes of the timer
// Assumes: 3-bit byte address, 8-bit register data
// Notes: included by the package users by bare name
`ifndef SDT_PARAMS_SVH
`define SDT_PARAMS_SVH

// register offsets
`define SDT_ADDR_CTRL0 3'h0
`define SDT_ADDR_CTRL1 3'h1
`define SDT_ADDR_CNT_LO 3'h2
`define SDT_ADDR_CNT_HI 3'h3
`define SDT_ADDR_CMPA_LO 3'h4
`define SDT_ADDR_CMPA_HI 3'h5
`define SDT_ADDR_PERIOD 3'h6
`define SDT_ADDR_FLAGS 3'h7

// control zero fields
`define SDT_RUN_BIT 0

// control one fields
`define SDT_MODE_HI 7
`define SDT_MODE_LO 6
`define SDT_ACT_HI 5
`define SDT_ACT_LO 4
`define SDT_OC_BIT 3
`define SDT_POL_BIT 2
`define SDT_SWAP_BIT 1
`define SDT_CLRSEL_BIT 0

// flag register fields
`define SDT_FLAG_A_BIT 0
`define SDT_FLAG_P_BIT 1

// reset values
`define SDT_RST_BYTE 8'h00
`define SDT_RST_WORD 16'h0000

// mode field codes
`define SDT_MODE_CMP 2'h0
`define SDT_MODE_PWM 2'h2
`define SDT_MODE_TMR 2'h3

// pin action codes
`define SDT_ACT_NONE 2'h0
`define SDT_ACT_LOW 2'h1
`define SDT_ACT_HIGH 2'h2
`define SDT_ACT_TOGGLE 2'h3

// timing counts in timer clocks
`define SDT_FULL_PERIOD 17'h10000
`define SDT_LOW_BYTE_END 8'hff

`endif

// [shared/sdt_pkg.sv]
// Purpose: types shared by the standard timer design
// Assumes: codes of the mode field live in sdt_params.svh
// Notes: capture and single pulse codes fold into the timer behaviour
package sdt_pkg;

    // operating behaviour selected by the mode field
    typedef enum logic [1:0] {
        SDT_BEH_COMPARE,
        SDT_BEH_PWM,
        SDT_BEH_TIMER
    } sdt_beh_t;

endpackage : sdt_pkg

// [rtl/sdt_rst_sync.sv]
// Purpose: release of the asynchronous reset through two flip-flops
// Assumes: i_rst_b may drop at any time
// Notes: assertion is immediate, release takes two clock edges
`timescale 1ns/1ps
module sdt_rst_sync (
    input wire logic i_ref_clk, // timer clock
    input wire logic i_rst_b, // raw reset, active low
    output logic o_rst_b // released reset, active low
);
    logic meta_r;
    logic hold_r;

    // first stage feeds only the second
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            hold_r <= meta_r;
        end
    end

    assign o_rst_b = hold_r;

endmodule : sdt_rst_sync

// [rtl/sdt_compare.sv]
// Purpose: comparator A, comparator P and edge-aligned duty decision
// Assumes: count runs 0 .. period-1, a match marks the last count
// Notes: pure combinational, the caller gates matches with the run bit
`timescale 1ns/1ps
`include "sdt_params.svh"
module sdt_compare (
    input wire logic [15:0] i_count, // running count
    input wire logic [15:0] i_compare_a, // compare-A value
    input wire logic [7:0] i_period_value, // period value, upper byte
    input wire logic i_swap, // duty/period swap
    output logic o_a_match, // count at compare-A terminal
    output logic o_a_zero, // compare-A value is zero
    output logic o_p_match, // count at period terminal
    output logic o_pwm_active // waveform in its active part
);
    logic [7:0] p_term;
    logic [16:0] span_p;
    logic [16:0] span_a;
    logic [16:0] period_len;
    logic [16:0] duty_len;

    // terminal counts; zero values wrap to ffff, i.e. overflow
    assign o_a_zero = (i_compare_a == `SDT_RST_WORD);
    assign o_a_match = (i_count == (i_compare_a - 16'h0001));
    assign p_term = i_period_value - 8'h01;
    assign o_p_match = (i_count[15:8] == p_term) &&
                       (i_count[7:0] == `SDT_LOW_BYTE_END);

    // lengths in clocks; zero means the full 65536, except compare-A used as duty, where zero stays zero
    assign span_p = (i_period_value == `SDT_RST_BYTE) ? `SDT_FULL_PERIOD :
                    {1'b0, i_period_value, 8'h00};
    assign span_a = o_a_zero ? `SDT_FULL_PERIOD : {1'b0, i_compare_a};
    assign period_len = i_swap ? span_a : span_p;
    assign duty_len = i_swap ? span_p : {1'b0, i_compare_a};

    // duty not below period gives a steady active level
    assign o_pwm_active = (duty_len >= period_len) ||
                          ({1'b0, i_count} < duty_len);

endmodule : sdt_compare

// [tb/sdt_load_model.sv]
// Purpose: external load on the timer output pin
// Assumes: the pin line has a weak pull-down while undriven
// Notes: a plain duty meter, counts edges that see the line high
`timescale 1ns/1ps
module sdt_load_model (
    input wire logic i_ref_clk, // timer clock
    input wire logic i_pin, // pin level from the timer
    input wire logic i_pin_oe, // timer drives the pin
    input wire logic i_clr, // restart the high count
    output logic [15:0] o_high_cnt // edges seen high since clear
);
    logic line;

    // undriven pin falls to the pull-down, never keeps its last level
    assign line = i_pin_oe ? i_pin : 1'b0;

    // no glitch filter, so a one-cycle spike is counted too
    always_ff @(posedge i_ref_clk) begin
        if (i_clr) begin
            o_high_cnt <= 16'h0000;
        end else if (line) begin
            o_high_cnt <= o_high_cnt + 16'h0001;
        end
    end
endmodule : sdt_load_model

// [tb/testbench.sv]
// Purpose: self-checking bench of the standard timer
// Assumes: write data visible the cycle after the strobe edge
// Notes: status word is {pin enable, pin, flag p, flag a}
`timescale 1ns/1ps
`include "sdt_params.svh"
module testbench;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic ld_clr = 1'b0;
    logic [7:0] o_rdata;
    logic o_timer_output_pin;
    logic o_timer_output_pin_oe;
    logic o_compare_a_flag;
    logic o_compare_p_flag;
    logic o_run;
    logic [15:0] high_cnt;
    logic [3:0] st;
    logic [7:0] rd_val;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    // pwm cases: ctrl one, compare-a, expected high edges
    logic [7:0] pw_c1 [7] = '{8'hb8, 8'hbc, 8'hb0, 8'hb8, 8'hbb, 8'h88,
        8'h98};
    logic [15:0] pw_a [7] = '{16'h0040, 16'h0040, 16'h0040, 16'h0100,
        16'h0200, 16'h0040, 16'h0040};
    logic [15:0] pw_e [7] = '{16'h0040, 16'h00c0, 16'h00c0, 16'h0100,
        16'h0100, 16'h0000, 16'h0100};
    logic [7:0] rb_e [5] = '{8'h00, 8'h00, 8'h5a, 8'ha5, 8'h3c};

    always #5 i_ref_clk = ~i_ref_clk;

    assign st = {o_timer_output_pin_oe, o_timer_output_pin,
        o_compare_p_flag, o_compare_a_flag};

    sdt_timer dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_timer_output_pin(o_timer_output_pin),
        .o_timer_output_pin_oe(o_timer_output_pin_oe),
        .o_compare_a_flag(o_compare_a_flag),
        .o_compare_p_flag(o_compare_p_flag), .o_run(o_run));

    sdt_load_model load (.i_ref_clk(i_ref_clk), .i_pin(o_timer_output_pin),
        .i_pin_oe(o_timer_output_pin_oe), .i_clr(ld_clr),
        .o_high_cnt(high_cnt));

    task automatic end_sim();
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cst(input logic [3:0] e);
        chk("status", 16'(e), 16'(st));
    endtask : cst

    // strobe stands for exactly one sampling edge, then a quiet cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr

    // read data only stand in the cycle after the strobe edge
    task automatic rd(input logic [2:0] a);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    // timer is stopped before pin action changes
    task automatic cfg(input logic [7:0] c1, input logic [15:0] a,
        input logic [7:0] p);
        wr(`SDT_ADDR_CTRL0, 8'h00);
        wr(`SDT_ADDR_CTRL1, c1);
        wr(`SDT_ADDR_CMPA_LO, a[7:0]);
        wr(`SDT_ADDR_CMPA_HI, a[15:8]);
        wr(`SDT_ADDR_PERIOD, p);
        wr(`SDT_ADDR_FLAGS, 8'h03);
        wr(`SDT_ADDR_CTRL0, 8'h01);
    endtask : cfg

    // window skips the start-up cycles, covers one whole period
    task automatic mwin(input int n);
        repeat (3) @(posedge i_ref_clk);
        ld_clr <= 1'b1;
        @(posedge i_ref_clk);
        ld_clr <= 1'b0;
        tick(n);
    endtask : mwin

    // hang guard, well above the longest expected run
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            $display("Error cycle limit expected %0d seen %0d", 89999, cyc);
            end_sim();
        end
    end

    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        tick(3);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0]);
            chk("reset value", 16'h0000, {8'h00, rd_val});
        end
        // count bytes must refuse writes
        wr(`SDT_ADDR_CNT_LO, 8'h77);
        wr(`SDT_ADDR_CNT_HI, 8'h77);
        wr(`SDT_ADDR_CMPA_LO, 8'h5a);
        wr(`SDT_ADDR_CMPA_HI, 8'ha5);
        wr(`SDT_ADDR_PERIOD, 8'h3c);
        for (int a = 2; a < 7; a++) begin
            rd(a[2:0]);
            chk("readback", {8'h00, rb_e[a-2]}, {8'h00, rd_val});
        end
        // compare mode, clear on p, toggle from low
        cfg(8'h30, 16'h0010, 8'h01); // mode 00
        tick(15);
        cst(4'b1000);
        tick(1);
        cst(4'b1001); // flag before pin
        tick(1);
        cst(4'b1101); // toggled
        tick(238);
        cst(4'b1101);
        tick(1);
        cst(4'b1111); // p match leaves pin
        tick(16);
        cst(4'b1111);
        tick(1);
        cst(4'b1011); // counter restarted at p
        // clear on a; p below a must not flag
        cfg(8'h19, 16'h0300, 8'h01);
        tick(2);
        cst(4'b1100); // restored initial high
        tick(765);
        cst(4'b1100);
        tick(1);
        cst(4'b1101);
        tick(1);
        cst(4'b1001); // driven low
        wr(`SDT_ADDR_FLAGS, 8'h03);
        tick(764);
        cst(4'b1000);
        tick(1);
        cst(4'b1001); // counter cleared on a
        wr(`SDT_ADDR_CTRL1, 8'hd9);
        tick(2);
        chk("pin enable", 16'h0000, 16'(o_timer_output_pin_oe));
        chk("run bit", 16'h0001, 16'(o_run));
        // zero compare-a and zero period: full overflow
        cfg(8'h20, 16'h0000, 8'h00);
        tick(1000);
        rd(`SDT_ADDR_CNT_HI);
        chk("count high", 16'h0003, {8'h00, rd_val});
        tick(64533);
        cst(4'b1000);
        tick(1);
        cst(4'b1010); // no a flag
        // set-high and no-action codes
        for (int i = 0; i < 2; i++) begin
            cfg(i == 0 ? 8'h20 : 8'h00, 16'h0004, 8'h01);
            tick(3);
            cst(4'b1000);
            tick(2);
            cst(i == 0 ? 4'b1101 : 4'b1001);
        end
        // pwm table: duty, polarity, swap, full duty, forced levels
        for (int i = 0; i < 7; i++) begin
            cfg(pw_c1[i], pw_a[i], 8'h01); // mode 10
            mwin(i == 4 ? 512 : 256);
            chk("high edges", pw_e[i], high_cnt);
            chk("pwm flags", 16'h0007, {13'h0000, st[3], st[1:0]});
        end
        end_sim();
    end
endmodule : testbench
